// file: afr_filter_result.sv
module afr_filter_result #(
  parameter int DATA_W  = 16,
  parameter int XFORM_W = 18
) (
  input  wire logic               i_mclk,
  input  wire logic               i_resetn,
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic      [31:0]        o_hrdata,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  input  wire logic               i_raw_valid,
  input  wire logic [DATA_W-1:0]  i_raw_data,
  input  wire logic               i_sinc3_valid,
  input  wire logic [DATA_W-1:0]  i_sinc3_data,
  input  wire logic               i_gainof_valid,
  input  wire logic [DATA_W-1:0]  i_gainof_data,
  input  wire logic               i_notch_valid,
  input  wire logic [DATA_W-1:0]  i_notch_data,
  input  wire logic               i_avg_valid,
  input  wire logic [DATA_W-1:0]  i_avg_data,
  input  wire logic               i_xform_valid,
  input  wire logic [XFORM_W-1:0] i_xform_real,
  input  wire logic [XFORM_W-1:0] i_xform_imag,
  input  wire logic               i_temp_valid,
  input  wire logic [DATA_W-1:0]  i_temp_data,
  output logic                    o_rate_800k,
  output logic                    o_sinc3_bypass,
  output logic                    o_notch_bypass,
  output logic                    o_avg_enable,
  output logic                    o_xform_valid,
  output logic      [DATA_W-1:0]  o_xform_data,
  output logic      [3:0]         o_xform_src,
  output logic                    o_irq
);
  logic [31:0]          filter_control;
  logic [31:0]          transform_config;
  logic [31:0]          irq_mask;
  logic [afr_pkg::FLAG_W-1:0] flags_first;
  logic [afr_pkg::FLAG_W-1:0] flags_second;
  logic                 ap_valid;
  logic                 ap_write;
  logic [15:0]          ap_addr;
  logic                 dp_write;
  logic [15:0]          dp_addr;
  logic                 dp_read;
  logic [15:0]          rd_addr;
  logic [afr_pkg::FLAG_W-1:0] event_set;
  logic [afr_pkg::FLAG_W-1:0] rd_flags;
  logic                 clr_first;
  logic                 clr_second;
  logic                 wr_filter_ctrl;
  logic                 wr_xform_config;
  logic                 wr_irq_mask;
  logic                 raw_sel_valid;
  logic [DATA_W-1:0]    raw_sel_data;
  afr_pkg::afr_insel_t  insel;
  afr_pkg::afr_src_t    next_src;
  logic                 next_valid;
  logic [DATA_W-1:0]    next_data;
  logic [31:0]          next_rdata;

  afr_result_if raw_if ();
  afr_result_if real_if ();
  afr_result_if imag_if ();
  afr_result_if notch_if ();
  afr_result_if temp_if ();

  afr_result_reg #(.W(DATA_W)) u_raw (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .rif      (raw_if.store)
  );
  afr_result_reg #(.W(XFORM_W)) u_real (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .rif      (real_if.store)
  );
  afr_result_reg #(.W(XFORM_W)) u_imag (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .rif      (imag_if.store)
  );
  afr_result_reg #(.W(DATA_W)) u_notch (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .rif      (notch_if.store)
  );
  afr_result_reg #(.W(DATA_W)) u_temp (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .rif      (temp_if.store)
  );

  // bus address phase capture
  assign ap_valid = i_hsel & i_hready & i_htrans[1];
  assign ap_write = ap_valid & i_hwrite;
  assign ap_addr  = i_haddr[15:0];

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      dp_write <= 1'b0;
      dp_read  <= 1'b0;
      dp_addr  <= 16'h0000;
    end else begin
      dp_write <= ap_write;
      dp_read  <= ap_valid & ~i_hwrite;
      dp_addr  <= ap_addr;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // control registers, written in the data phase
  assign wr_filter_ctrl  = dp_write & (dp_addr == afr_pkg::ADDR_FILTER_CTRL);
  assign wr_xform_config = dp_write & (dp_addr == afr_pkg::ADDR_XFORM_CONFIG);
  assign wr_irq_mask     = dp_write & (dp_addr == afr_pkg::ADDR_IRQ_MASK);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      filter_control <= afr_pkg::FILTER_CTRL_RESET;
    end else if (wr_filter_ctrl) begin
      filter_control <= i_hwdata & afr_pkg::FILTER_CTRL_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      transform_config <= afr_pkg::XFORM_CONFIG_RESET;
    end else if (wr_xform_config) begin
      transform_config <= i_hwdata & afr_pkg::XFORM_CONFIG_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask <= 32'h0000_0000;
    end else if (wr_irq_mask) begin
      irq_mask <= {{(32-afr_pkg::FLAG_W){1'b0}},
                   i_hwdata[afr_pkg::FLAG_W-1:0]};
    end
  end

  assign o_rate_800k    = filter_control[afr_pkg::FC_RATE_SELECT];
  assign o_sinc3_bypass = filter_control[afr_pkg::FC_SINC3_BYPASS];
  assign o_notch_bypass = filter_control[afr_pkg::FC_NOTCH_BYPASS];
  assign o_avg_enable   = filter_control[afr_pkg::FC_AVG_ENABLE];
  assign insel = afr_pkg::afr_insel_t'(
    transform_config[afr_pkg::XC_INSEL_LSB +: 2]);

  // raw result: sinc3 output unless bypassed
  always_comb begin
    if (o_sinc3_bypass) begin
      raw_sel_valid = i_raw_valid;
      raw_sel_data  = i_raw_data;
    end else begin
      raw_sel_valid = i_sinc3_valid;
      raw_sel_data  = i_sinc3_data;
    end
  end

  // transform source selection
  always_comb begin
    next_src = afr_pkg::AFR_SRC_NOTCH;
    if (o_avg_enable) begin
      next_src = afr_pkg::AFR_SRC_AVERAGE;
    end else if (o_sinc3_bypass && o_rate_800k) begin
      next_src = afr_pkg::AFR_SRC_GAINOF;
    end else begin
      case (insel)
        afr_pkg::AFR_SEL_GAINOF: next_src = afr_pkg::AFR_SRC_GAINOF;
        afr_pkg::AFR_SEL_RAW:    next_src = afr_pkg::AFR_SRC_RAW;
        default:                 next_src = afr_pkg::AFR_SRC_NOTCH;
      endcase
    end
  end

  always_comb begin
    case (next_src)
      afr_pkg::AFR_SRC_AVERAGE: begin
        next_valid = i_avg_valid;
        next_data  = i_avg_data;
      end
      afr_pkg::AFR_SRC_GAINOF: begin
        next_valid = i_gainof_valid;
        next_data  = i_gainof_data;
      end
      afr_pkg::AFR_SRC_RAW: begin
        next_valid = i_raw_valid;
        next_data  = i_raw_data;
      end
      default: begin
        next_valid = i_notch_valid & ~o_notch_bypass;
        next_data  = i_notch_data;
      end
    endcase
  end

  // registered feed into the transform engine
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_xform_valid <= 1'b0;
      o_xform_data  <= '0;
      o_xform_src   <= afr_pkg::AFR_SRC_NOTCH;
    end else begin
      o_xform_valid <= next_valid;
      o_xform_src   <= next_src;
      if (next_valid) begin
        o_xform_data <= next_data;
      end
    end
  end

  // result register loads
  assign raw_if.load        = raw_sel_valid;
  assign raw_if.next_word   = {{(32-DATA_W){1'b0}}, raw_sel_data};
  assign real_if.load       = i_xform_valid;
  assign real_if.next_word  = {{(32-XFORM_W){1'b0}}, i_xform_real};
  assign imag_if.load       = i_xform_valid;
  assign imag_if.next_word  = {{(32-XFORM_W){1'b0}}, i_xform_imag};
  assign notch_if.load      = i_notch_valid & ~o_notch_bypass;
  assign notch_if.next_word = {{(32-DATA_W){1'b0}}, i_notch_data};
  assign temp_if.load       = i_temp_valid;
  assign temp_if.next_word  = {{(32-DATA_W){1'b0}}, i_temp_data};

  // sticky event flags, set wins over read clear
  always_comb begin
    event_set = '0;
    event_set[afr_pkg::FLAG_RAW]   = raw_sel_valid;
    event_set[afr_pkg::FLAG_XFORM] = i_xform_valid;
    event_set[afr_pkg::FLAG_NOTCH] = notch_if.load;
    event_set[afr_pkg::FLAG_TEMP]  = i_temp_valid;
  end

  assign clr_first  = dp_read & (dp_addr == afr_pkg::ADDR_FLAGS_FIRST);
  assign clr_second = dp_read & (dp_addr == afr_pkg::ADDR_FLAGS_SECOND);
  // only the bits already handed out are cleared
  assign rd_flags   = o_hrdata[afr_pkg::FLAG_W-1:0];

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_first <= '0;
    end else if (clr_first) begin
      flags_first <= (flags_first & ~rd_flags) | event_set;
    end else begin
      flags_first <= flags_first | event_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_second <= '0;
    end else if (clr_second) begin
      flags_second <= (flags_second & ~rd_flags) | event_set;
    end else begin
      flags_second <= flags_second | event_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((flags_first | flags_second)
                 & irq_mask[afr_pkg::FLAG_W-1:0]);
    end
  end

  // read data, registered in the address phase
  assign rd_addr = ap_addr;

  always_comb begin
    case (rd_addr)
      afr_pkg::ADDR_RAW_RESULT:   next_rdata = raw_if.word;
      afr_pkg::ADDR_REAL_RESULT:  next_rdata = real_if.word;
      afr_pkg::ADDR_IMAG_RESULT:  next_rdata = imag_if.word;
      afr_pkg::ADDR_NOTCH_RESULT: next_rdata = notch_if.word;
      afr_pkg::ADDR_TEMP_RESULT:  next_rdata = temp_if.word;
      afr_pkg::ADDR_XFORM_CONFIG: next_rdata = transform_config;
      afr_pkg::ADDR_FILTER_CTRL:  next_rdata = filter_control;
      afr_pkg::ADDR_FLAGS_FIRST:
        next_rdata = {{(32-afr_pkg::FLAG_W){1'b0}}, flags_first};
      afr_pkg::ADDR_FLAGS_SECOND:
        next_rdata = {{(32-afr_pkg::FLAG_W){1'b0}}, flags_second};
      afr_pkg::ADDR_IRQ_MASK:     next_rdata = irq_mask;
      default:                    next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hrdata <= 32'h0000_0000;
    end else if (ap_valid && !i_hwrite) begin
      o_hrdata <= next_rdata;
    end
  end
endmodule : afr_filter_result

// file: afr_pkg.sv
package afr_pkg;
  localparam logic [15:0] ADDR_RAW_RESULT   = 16'h2074;
  localparam logic [15:0] ADDR_REAL_RESULT  = 16'h2078;
  localparam logic [15:0] ADDR_IMAG_RESULT  = 16'h207C;
  localparam logic [15:0] ADDR_NOTCH_RESULT = 16'h2080;
  localparam logic [15:0] ADDR_TEMP_RESULT  = 16'h2084;
  localparam logic [15:0] ADDR_XFORM_CONFIG = 16'h20D0;
  localparam logic [15:0] ADDR_FILTER_CTRL  = 16'h20A8;
  localparam logic [15:0] ADDR_FLAGS_FIRST  = 16'h3000;
  localparam logic [15:0] ADDR_FLAGS_SECOND = 16'h3004;
  localparam logic [15:0] ADDR_IRQ_MASK     = 16'h3008;

  localparam logic [31:0] XFORM_CONFIG_RESET = 32'h0000_0090;
  localparam logic [31:0] XFORM_CONFIG_MASK  = 32'h0030_00F1;
  localparam logic [31:0] FILTER_CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] FILTER_CTRL_MASK   = 32'h0000_00D1;

  localparam int FC_RATE_SELECT  = 0;
  localparam int FC_NOTCH_BYPASS = 4;
  localparam int FC_SINC3_BYPASS = 6;
  localparam int FC_AVG_ENABLE   = 7;
  localparam int XC_INSEL_LSB    = 20;

  localparam int FLAG_RAW   = 0;
  localparam int FLAG_XFORM = 1;
  localparam int FLAG_NOTCH = 2;
  localparam int FLAG_TEMP  = 3;
  localparam int FLAG_W     = 4;

  typedef enum logic [1:0] {
    AFR_SEL_NOTCH  = 2'h0,
    AFR_SEL_GAINOF = 2'h1,
    AFR_SEL_RAW    = 2'h2,
    AFR_SEL_NOTCH2 = 2'h3
  } afr_insel_t;

  typedef enum logic [3:0] {
    AFR_SRC_NOTCH   = 4'h1,
    AFR_SRC_GAINOF  = 4'h2,
    AFR_SRC_RAW     = 4'h4,
    AFR_SRC_AVERAGE = 4'h8
  } afr_src_t;
endpackage : afr_pkg

// file: afr_result_if.sv
interface afr_result_if;
  logic        load;
  logic [31:0] next_word;
  logic [31:0] word;
  modport owner (output load, output next_word, input word);
  modport store (input load, input next_word, output word);
endinterface : afr_result_if

// file: afr_result_reg.sv
module afr_result_reg #(
  parameter int W = 16
) (
  input  wire logic   i_mclk,
  input  wire logic   i_resetn,
  afr_result_if.store rif
);
  logic [W-1:0] held;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      held <= '0;
    end else if (rif.load) begin
      held <= rif.next_word[W-1:0];
    end
  end

  assign rif.word = {{(32-W){1'b0}}, held};
endmodule : afr_result_reg

// file: afr_filter_result_sva.sv
module afr_filter_result_sva #(
  parameter int DATA_W = 16
) (
  input wire logic              i_mclk,
  input wire logic              i_resetn,
  input wire logic              i_hsel,
  input wire logic [31:0]       i_haddr,
  input wire logic [1:0]        i_htrans,
  input wire logic              i_hwrite,
  input wire logic [31:0]       i_hwdata,
  input wire logic              i_hready,
  input wire logic              i_raw_valid,
  input wire logic              i_gainof_valid,
  input wire logic [DATA_W-1:0] i_gainof_data,
  input wire logic              i_notch_valid,
  input wire logic              i_avg_valid,
  input wire logic [DATA_W-1:0] i_avg_data,
  input wire logic              o_rate_800k,
  input wire logic              o_sinc3_bypass,
  input wire logic              o_notch_bypass,
  input wire logic              o_avg_enable,
  input wire logic              o_xform_valid,
  input wire logic [DATA_W-1:0] o_xform_data,
  input wire logic [3:0]        o_xform_src
);
  timeunit 1ns;
  timeprecision 1ns;
  logic any_v;
  assign any_v = i_raw_valid | i_gainof_valid | i_notch_valid | i_avg_valid;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);
  // filter control write, address then data phase
  sequence wr_ctrl;
    i_hsel && i_hready && i_htrans[1] && i_hwrite &&
      i_haddr[15:0] == afr_pkg::ADDR_FILTER_CTRL ##1 i_hready;
  endsequence
  rate_sel_a: assert property (
    wr_ctrl |=> o_rate_800k == $past(i_hwdata[0]))
    else $error("rate select not loaded");
  sinc3_byp_a: assert property (
    wr_ctrl |=> o_sinc3_bypass == $past(i_hwdata[6]))
    else $error("third-order bypass not loaded");
  notch_byp_a: assert property (
    wr_ctrl |=> o_notch_bypass == $past(i_hwdata[4]))
    else $error("notch bypass not loaded");
  avg_feed_a: assert property (
    o_avg_enable && i_avg_valid |=> o_xform_valid &&
      o_xform_src == 4'h8 && o_xform_data == $past(i_avg_data))
    else $error("average not fed to transform");
  gainof_feed_a: assert property (
    !o_avg_enable && o_sinc3_bypass && o_rate_800k && i_gainof_valid
      |=> o_xform_valid && o_xform_src == 4'h2 &&
      o_xform_data == $past(i_gainof_data))
    else $error("correction output not fed to transform");
  xform_cause_a: assert property (
    o_xform_valid |-> $past(any_v))
    else $error("transform word without a source word");
  xform_hold_a: assert property (
    !o_xform_valid |-> $stable(o_xform_data))
    else $error("transform word changed without valid");
  notch_gate_a: assert property (
    o_xform_valid && o_xform_src == 4'h1 |-> !$past(o_notch_bypass))
    else $error("bypassed notch word reached transform");
endmodule : afr_filter_result_sva

bind afr_filter_result afr_filter_result_sva #(.DATA_W(DATA_W)) u_sva (.*);

// file: afr_stage_model.sv
module afr_stage_model (
  input  wire logic        i_mclk,
  input  wire logic [6:0]  i_go,
  input  wire logic [17:0] i_word,
  input  wire logic [17:0] i_imag,
  output logic      [6:0]  o_valid,
  output logic      [17:0] o_real,
  output logic      [17:0] o_imag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [17:0] last = 18'h2AAAA;
  always @(posedge i_mclk) last <= o_real;
  assign o_valid = i_go;
  // stale data toggles every cycle outside a valid pulse
  assign o_real = (|i_go) ? i_word : ~last;
  assign o_imag = (|i_go) ? i_imag : last;
endmodule : afr_stage_model

// file: afr_filter_result_tb_top.sv
module afr_filter_result_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, hsel, hwrite, hready, hresp, rate, s3b, nb, ae, xv, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] xdata;
  logic [3:0]  xsrc;
  logic [6:0]  go, v;
  logic [17:0] word, imag, rl, im;
  int          fails, tests_run, oth;
  logic [15:0] ra[9] = '{16'h2074, 16'h2078, 16'h207C, 16'h2080, 16'h2084,
                         16'h20D0, 16'h20A8, 16'h3000, 16'h1000};
  logic [7:0]  tc[8] = '{8'h80, 8'h80, 8'hC1, 8'h41, 8'h01, 0, 0, 0};
  logic [1:0]  tg[8] = '{0, 2, 2, 2, 2, 1, 3, 0};
  int          ts[8] = '{4, 4, 4, 2, 0, 2, 3, 3};
  logic [3:0]  te[8] = '{4'h8, 4'h8, 4'h8, 4'h2, 4'h4, 4'h2, 4'h1, 4'h1};
  afr_stage_model u_model (.i_mclk(mclk), .i_go(go), .i_word(word),
    .i_imag(imag), .o_valid(v), .o_real(rl), .o_imag(im));
  afr_filter_result u_dut (.i_mclk(mclk), .i_resetn(resetn), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_raw_valid(v[0]),
    .i_raw_data(rl[15:0]), .i_sinc3_valid(v[1]), .i_sinc3_data(rl[15:0]),
    .i_gainof_valid(v[2]), .i_gainof_data(rl[15:0]), .i_notch_valid(v[3]),
    .i_notch_data(rl[15:0]), .i_avg_valid(v[4]), .i_avg_data(rl[15:0]),
    .i_xform_valid(v[5]), .i_xform_real(rl), .i_xform_imag(im),
    .i_temp_valid(v[6]), .i_temp_data(rl[15:0]), .o_rate_800k(rate),
    .o_sinc3_bypass(s3b), .o_notch_bypass(nb), .o_avg_enable(ae),
    .o_xform_valid(xv), .o_xform_data(xdata), .o_xform_src(xsrc),
    .o_irq(irq));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t ns: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0000, a};
    hwrite <= w;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic fire(input int s, input logic [17:0] w, input logic [17:0] m);
    word <= w;
    imag <= m;
    go <= 7'h01 << s;
    @(posedge mclk);
    go <= 7'h00;
    @(posedge mclk);
  endtask : fire
  task automatic test_done;
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  initial begin
    {resetn, hsel, hwrite, htrans, haddr, hwdata, go, word, imag} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    foreach (ra[i]) rd(ra[i], (i == 5) ? 32'h90 : 32'h0);
    wr(16'h20A8, 32'hFFFF_FFFF);
    rd(16'h20A8, 32'hD1);
    chk({28'h0, rate, s3b, nb, ae}, 32'hF);
    chk({31'h0, hresp}, 32'h0);
    wr(16'h20D0, 32'hFFFF_FFFF);
    rd(16'h20D0, 32'h0030_00F1);
    wr(16'h20A8, 32'h0);
    $display("test registers done");
    fire(1, 18'h3ABCD, 0);
    fire(0, 18'h01234, 0);
    rd(16'h2074, 32'hABCD);
    fire(5, 18'h20001, 18'h3FFFF);
    rd(16'h2078, 32'h20001);
    rd(16'h207C, 32'h3FFFF);
    fire(6, 18'h08001, 0);
    rd(16'h2084, 32'h8001);
    fire(3, 18'h0F00F, 0);
    rd(16'h2080, 32'hF00F);
    rd(16'h3000, 32'hF);
    rd(16'h3000, 32'h0);
    rd(16'h3004, 32'hF);
    wr(16'h20A8, 32'h50);
    fire(3, 18'h01111, 0);
    fire(0, 18'h02222, 0);
    rd(16'h2080, 32'hF00F);
    rd(16'h2074, 32'h2222);
    rd(16'h3000, 32'h1);
    rd(16'h3004, 32'h1);
    $display("test results done");
    wr(16'h3008, 32'h4);
    wr(16'h20A8, 32'h0);
    fire(3, 18'h00777, 0);
    @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    rd(16'h3000, 32'h4);
    rd(16'h3004, 32'h4);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    foreach (ts[i]) begin
      oth = (ts[i] == 4) ? 3 : 4;
      wr(16'h20A8, {24'h0, tc[i]});
      wr(16'h20D0, {10'h0, tg[i], 20'h00090});
      fire(oth, ~(18'h05A00 + 18'(i)), 0);
      fire(ts[i], 18'h05A00 + 18'(i), 0);
      chk({28'h0, xsrc}, {28'h0, te[i]});
      chk({16'h0, xdata}, 32'h5A00 + 32'(i));
    end
    $display("test source done");
    test_done;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    test_done;
  end
endmodule : afr_filter_result_tb_top
